// ==== logic/tx_err_mon_consts.vh ====
// Purpose: Offsets, field positions, reset values and codes of the
//          transmit error-insertion and monitor register bank.
// Assumes: Register index = byte address / 4 on a 32-bit bus.
// Notes:   Definitions only.
`ifndef TX_ERR_MON_CONSTS_VH
`define TX_ERR_MON_CONSTS_VH

// Register indexes, byte address is four times the index
`define IDX_PROC_CTRL      8'hC4
`define IDX_ERR_COUNT      8'hC6
`define IDX_ERR_RATE       8'hC7
`define IDX_INS_STATUS     8'hC8
`define IDX_INS_LATCHED    8'hC9
`define IDX_INS_IRQ_EN     8'hCA
`define IDX_PKT_CNT_B0     8'hCC
`define IDX_PKT_CNT_B1     8'hCD
`define IDX_PKT_CNT_B2     8'hCE
`define IDX_BYTE_CNT_B0    8'hD0
`define IDX_BYTE_CNT_B1    8'hD1
`define IDX_BYTE_CNT_B2    8'hD2
`define IDX_BYTE_CNT_B3    8'hD3
`define IDX_MANUAL_ERR     8'hD4
`define IDX_MON_UPDATE     8'hD6
`define IDX_MON_UPD_STATUS 8'hD7

// Field positions
`define BIT_AUTO_INIT      0
`define BIT_FLAG0          0
`define BIT_MANUAL_SEL     7

// Reset values
`define RST_BYTE           8'h00
`define RST_WORD           32'h0000_0000

// Count value meaning endless insertion
`define ERR_COUNT_ENDLESS  8'hFF
// Largest decade exponent of the rate field
`define RATE_EXP_MAX       3'h6

`endif

// ==== logic/err_insert_engine.v ====
// Purpose: Automatic errored-packet insertion, one in x*10^y packets.
// Assumes: start and stop are one-cycle pulses from the register bank.
// Notes:   Rate changes during a run take effect on the next packet.
`timescale 1ns/1ps
`default_nettype none
`include "tx_err_mon_consts.vh"

module err_insert_engine (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire stop,
    input wire [7:0] errored_packet_total,
    input wire [6:0] errored_packet_rate,
    input wire pkt_start,
    output reg pkt_corrupt,
    output reg insert_finished
);

    reg active_reg;
    reg [23:0] rate_cnt_reg;
    reg [7:0] err_cnt_reg;
    wire rate_off;
    wire endless;
    wire [23:0] period;
    wire hit;

    // Period is x times ten to the y, exponent capped at six
    function [23:0] rate_period;
        input [6:0] r;
        reg [2:0] y;
        reg [23:0] p;
        reg [47:0] prod;
        begin
            y = (r[6:4] > `RATE_EXP_MAX) ? `RATE_EXP_MAX : r[6:4];
            case (y)
                3'h0: p = 24'h000001;
                3'h1: p = 24'h00000A;
                3'h2: p = 24'h000064;
                3'h3: p = 24'h0003E8;
                3'h4: p = 24'h002710;
                3'h5: p = 24'h0186A0;
                default: p = 24'h0F4240;
            endcase
            prod = {20'h00000, r[3:0]} * p;
            rate_period = prod[23:0];
        end
    endfunction

    assign rate_off = (errored_packet_rate[3:0] == 4'h0);
    assign endless = (errored_packet_total == `ERR_COUNT_ENDLESS);
    assign period = rate_period(errored_packet_rate);
    // Compare with >= so a shortened period mid-run cannot skip past
    assign hit = (rate_cnt_reg >= period - 24'h000001);

    // Run control, rate counting and completion
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
            rate_cnt_reg <= 24'h000000;
            err_cnt_reg <= 8'h00;
            pkt_corrupt <= 1'b0;
            insert_finished <= 1'b0;
        end else begin
            pkt_corrupt <= 1'b0;
            if (start) begin
                active_reg <= !rate_off;
                rate_cnt_reg <= 24'h000000;
                err_cnt_reg <= 8'h00;
                insert_finished <= 1'b0;
            end else if (stop || rate_off) begin
                active_reg <= 1'b0;
                insert_finished <= 1'b0;
            end else if (active_reg && pkt_start) begin
                if (hit) begin
                    pkt_corrupt <= 1'b1;
                    rate_cnt_reg <= 24'h000000;
                    if (!endless) begin
                        err_cnt_reg <= err_cnt_reg + 8'h01;
                        if (err_cnt_reg + 8'h01 >= errored_packet_total) begin
                            active_reg <= 1'b0;
                            insert_finished <= 1'b1;
                        end
                    end
                end else begin
                    rate_cnt_reg <= rate_cnt_reg + 24'h000001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/perf_snapshot.v ====
// Purpose: Live packet and byte counters with snapshot on update request.
// Assumes: Events are one-cycle pulses on the same clock.
// Notes:   Snapshots only change on an update, so multi-byte reads agree.
`timescale 1ns/1ps
`default_nettype none
`include "tx_err_mon_consts.vh"

module perf_snapshot (
    input wire clk,
    input wire rst_n,
    input wire tx_monitor_update_req,
    input wire pkt_evt,
    input wire byte_evt,
    output reg [23:0] tx_packet_count,
    output reg [31:0] tx_byte_count,
    output reg tx_monitor_update_done
);

    localparam ST_IDLE = 2'b00;
    localparam ST_LOADED = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0] state_reg;
    reg req_q_reg;
    reg [23:0] pkt_live_reg;
    reg [31:0] byte_live_reg;
    wire req_rise;

    assign req_rise = tx_monitor_update_req && !req_q_reg;

    // Update sequence: load, restart counters, then report done
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            req_q_reg <= 1'b0;
            pkt_live_reg <= 24'h000000;
            byte_live_reg <= `RST_WORD;
            tx_packet_count <= 24'h000000;
            tx_byte_count <= `RST_WORD;
            tx_monitor_update_done <= 1'b0;
        end else begin
            req_q_reg <= tx_monitor_update_req;
            if (req_rise) begin
                tx_packet_count <= pkt_live_reg;
                tx_byte_count <= byte_live_reg;
                pkt_live_reg <= {23'h000000, pkt_evt};
                byte_live_reg <= {31'h00000000, byte_evt};
                tx_monitor_update_done <= 1'b0;
                state_reg <= ST_LOADED;
            end else begin
                pkt_live_reg <= pkt_live_reg + {23'h000000, pkt_evt};
                byte_live_reg <= byte_live_reg + {31'h00000000, byte_evt};
                case (state_reg)
                    ST_LOADED: begin
                        tx_monitor_update_done <= tx_monitor_update_req;
                        state_reg <= tx_monitor_update_req ? ST_DONE : ST_IDLE;
                    end
                    ST_DONE: begin
                        if (!tx_monitor_update_req) begin
                            tx_monitor_update_done <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        tx_monitor_update_done <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/tx_packet_error_insert_monitor.v ====
// Purpose: Transmit packet error insertion and performance monitor bank.
// Assumes: Classic Wishbone slave, 8-bit registers in the low lane of
//          aligned 32-bit words; stream events come from same-clock logic.
// Notes:   Answers every access after one wait cycle.
//
// How it works
// - Finished flag sets after programmed errored packets.
// - Finished flag clears on disable or restart.
// - Latched finished sets on flag rising edge.
// - Latched bit holds until read, resets anew.
// - Interrupt when latched bit set and enabled.
// - Count per run, rate x times ten^y.
// - 24-bit packet count, three bytes, low first.
// - 32-bit byte count, four bytes, low first.
// - Manual bit rising edge inserts one error.
// - Manual insert needs mode select, auto continues.
// - Update rising edge snapshots and restarts counters.
// - Update status sets when done, clears later.
// - Status low during update, no event lost.
`timescale 1ns/1ps
`default_nettype none
`include "tx_err_mon_consts.vh"

module tx_packet_error_insert_monitor (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire pkt_start,
    input wire byte_sent,
    output wire pkt_corrupt,
    output reg manual_error,
    output reg irq
);

    // Software-visible control state and internal edge and pulse registers
    reg [5:1] tx_processor_ctrl_reg;
    reg [7:0] errored_count_ctrl_reg;
    reg [7:0] errored_rate_ctrl_reg;
    reg insert_finished_irq_en_reg;
    reg insert_finished_latched_reg;
    reg manual_error_pulse_reg;
    reg tx_monitor_update_req_reg;
    reg finished_q_reg;
    reg auto_start_reg;
    reg auto_stop_reg;

    wire [7:0] idx;
    wire access;
    wire wr_lane0;
    wire rd_take;
    wire [7:0] wbyte;
    wire insert_finished;
    wire [23:0] tx_packet_count;
    wire [31:0] tx_byte_count;
    wire tx_monitor_update_done;
    wire finished_rise;

    assign idx = wb_adr_i[9:2];
    // New request taken only when no answer is standing
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane0 = access && wb_we_i && wb_sel_i[0];
    assign rd_take = access && !wb_we_i;
    assign wbyte = wb_dat_i[7:0];

    // Decoder shared by write and read paths
    function is_reg;
        input [7:0] a;
        input [7:0] target;
        begin
            is_reg = (a == target);
        end
    endfunction

    // Read mux; unmapped and write-only locations read as zero
    function [7:0] read_byte;
        input [7:0] a;
        input [5:1] pctl;
        input [7:0] ecnt;
        input [7:0] erate;
        input fin;
        input fin_l;
        input ien;
        input [23:0] pcnt;
        input [31:0] bcnt;
        input man;
        input upd;
        input upd_done;
        begin
            if (a == `IDX_PROC_CTRL) begin
                read_byte = {2'b00, pctl, 1'b0};
            end else if (a == `IDX_ERR_COUNT) begin
                read_byte = ecnt;
            end else if (a == `IDX_ERR_RATE) begin
                read_byte = erate;
            end else if (a == `IDX_INS_STATUS) begin
                read_byte = {7'h00, fin};
            end else if (a == `IDX_INS_LATCHED) begin
                read_byte = {7'h00, fin_l};
            end else if (a == `IDX_INS_IRQ_EN) begin
                read_byte = {7'h00, ien};
            end else if (a == `IDX_PKT_CNT_B0) begin
                read_byte = pcnt[7:0];
            end else if (a == `IDX_PKT_CNT_B1) begin
                read_byte = pcnt[15:8];
            end else if (a == `IDX_PKT_CNT_B2) begin
                read_byte = pcnt[23:16];
            end else if (a == `IDX_BYTE_CNT_B0) begin
                read_byte = bcnt[7:0];
            end else if (a == `IDX_BYTE_CNT_B1) begin
                read_byte = bcnt[15:8];
            end else if (a == `IDX_BYTE_CNT_B2) begin
                read_byte = bcnt[23:16];
            end else if (a == `IDX_BYTE_CNT_B3) begin
                read_byte = bcnt[31:24];
            end else if (a == `IDX_MANUAL_ERR) begin
                read_byte = {7'h00, man};
            end else if (a == `IDX_MON_UPDATE) begin
                read_byte = {7'h00, upd};
            end else if (a == `IDX_MON_UPD_STATUS) begin
                read_byte = {7'h00, upd_done};
            end else begin
                read_byte = `RST_BYTE;
            end
        end
    endfunction

    // Bus answer: one wait cycle, ack for one cycle, data registered
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `RST_WORD;
        end else begin
            wb_ack_o <= access;
            if (rd_take) begin
                wb_dat_o <= {24'h000000, read_byte(idx, tx_processor_ctrl_reg,
                    errored_count_ctrl_reg, errored_rate_ctrl_reg, insert_finished,
                    insert_finished_latched_reg, insert_finished_irq_en_reg,
                    tx_packet_count, tx_byte_count, manual_error_pulse_reg,
                    tx_monitor_update_req_reg, tx_monitor_update_done)};
            end
        end
    end

    // Writable control registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_processor_ctrl_reg <= 5'h00;
            errored_count_ctrl_reg <= `RST_BYTE;
            errored_rate_ctrl_reg <= `RST_BYTE;
            insert_finished_irq_en_reg <= 1'b0;
            manual_error_pulse_reg <= 1'b0;
            tx_monitor_update_req_reg <= 1'b0;
        end else if (wr_lane0) begin
            if (is_reg(idx, `IDX_PROC_CTRL)) begin
                tx_processor_ctrl_reg <= wbyte[5:1];
            end else if (is_reg(idx, `IDX_ERR_COUNT)) begin
                errored_count_ctrl_reg <= wbyte;
            end else if (is_reg(idx, `IDX_ERR_RATE)) begin
                errored_rate_ctrl_reg <= wbyte;
            end else if (is_reg(idx, `IDX_INS_IRQ_EN)) begin
                insert_finished_irq_en_reg <= wbyte[`BIT_FLAG0];
            end else if (is_reg(idx, `IDX_MANUAL_ERR)) begin
                manual_error_pulse_reg <= wbyte[`BIT_FLAG0];
            end else if (is_reg(idx, `IDX_MON_UPDATE)) begin
                tx_monitor_update_req_reg <= wbyte[`BIT_FLAG0];
            end
        end
    end

    // Write-only initiate bit becomes start and stop pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_start_reg <= 1'b0;
            auto_stop_reg <= 1'b0;
        end else begin
            auto_start_reg <= wr_lane0 && is_reg(idx, `IDX_PROC_CTRL)
                && wbyte[`BIT_AUTO_INIT];
            auto_stop_reg <= wr_lane0 && is_reg(idx, `IDX_PROC_CTRL)
                && !wbyte[`BIT_AUTO_INIT];
        end
    end

    err_insert_engine u_engine (
        .clk(clk),
        .rst_n(rst_n),
        .start(auto_start_reg),
        .stop(auto_stop_reg),
        .errored_packet_total(errored_count_ctrl_reg),
        .errored_packet_rate(errored_rate_ctrl_reg[6:0]),
        .pkt_start(pkt_start),
        .pkt_corrupt(pkt_corrupt),
        .insert_finished(insert_finished)
    );

    assign finished_rise = insert_finished && !finished_q_reg;

    // Latched finished flag; a new rising edge beats a read clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            finished_q_reg <= 1'b0;
            insert_finished_latched_reg <= 1'b0;
        end else begin
            finished_q_reg <= insert_finished;
            if (finished_rise) begin
                insert_finished_latched_reg <= 1'b1;
            end else if (rd_take && is_reg(idx, `IDX_INS_LATCHED)) begin
                insert_finished_latched_reg <= 1'b0;
            end
        end
    end

    // Interrupt level follows the latched flag gated by its enable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= insert_finished_latched_reg && insert_finished_irq_en_reg;
        end
    end

    // Manual single error, edge of the control bit while mode selected;
    // automatic insertion keeps running beside it
    reg manual_q_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            manual_q_reg <= 1'b0;
            manual_error <= 1'b0;
        end else begin
            manual_q_reg <= manual_error_pulse_reg;
            manual_error <= manual_error_pulse_reg && !manual_q_reg
                && errored_rate_ctrl_reg[`BIT_MANUAL_SEL];
        end
    end

    perf_snapshot u_perf (
        .clk(clk),
        .rst_n(rst_n),
        .tx_monitor_update_req(tx_monitor_update_req_reg),
        .pkt_evt(pkt_start),
        .byte_evt(byte_sent),
        .tx_packet_count(tx_packet_count),
        .tx_byte_count(tx_byte_count),
        .tx_monitor_update_done(tx_monitor_update_done)
    );

endmodule
`default_nettype wire

// ==== verification/tdm_pkt_source.sv ====
// Purpose: Model of the serial transmit stream that feeds packet events.
// Assumes: go is a one-cycle request; every packet carries at least one byte.
// Notes:   Packets run back to back: a start pulse, then its byte pulses.
`timescale 1ns/1ps
`default_nettype none
module tdm_pkt_source (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [7:0] n_pkts,
    input wire logic [7:0] n_bytes,
    output logic pkt_start,
    output logic byte_sent,
    output logic busy
);
    logic [7:0] pk_left_reg;
    logic [7:0] by_left_reg;
    // Start and byte pulses never share a cycle, so counts stay exact
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_start <= 1'b0;
            byte_sent <= 1'b0;
            busy <= 1'b0;
            pk_left_reg <= 8'h00;
            by_left_reg <= 8'h00;
        end else begin
            pkt_start <= 1'b0;
            byte_sent <= 1'b0;
            if (go && !busy) begin
                pk_left_reg <= n_pkts;
                by_left_reg <= 8'h00;
                busy <= 1'b1;
            end else if (busy && by_left_reg != 8'h00) begin
                byte_sent <= 1'b1;
                by_left_reg <= by_left_reg - 8'h01;
                busy <= !(by_left_reg == 8'h01 && pk_left_reg == 8'h00);
            end else if (busy) begin
                pkt_start <= 1'b1;
                pk_left_reg <= pk_left_reg - 8'h01;
                by_left_reg <= n_bytes;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/tx_packet_error_insert_monitor_props.sv ====
// Purpose: Port-level checks of the error insertion and monitor bank.
// Assumes: Single clock; answer one cycle after the taking edge.
// Notes:   Internal flags are judged through irq and the bus.
`timescale 1ns/1ps
`default_nettype none
module tx_err_mon_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic pkt_start,
    input wire logic byte_sent,
    input wire logic pkt_corrupt,
    input wire logic manual_error,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence bus_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_timing_a: assert property (bus_taken |=> ack_pulse)
        else $error("ack not a single pulse one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper lanes not zero");
    rdata_hold_a: assert property (!$stable(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
        else $error("read data changed without a read");
    corrupt_cause_a: assert property (pkt_corrupt |-> $past(pkt_start))
        else $error("corrupt pulse without packet start");
    manual_single_a: assert property (manual_error |=> !manual_error)
        else $error("manual error longer than one cycle");
    manual_cause_a: assert property (manual_error |->
        $past(wb_cyc_i && wb_we_i && wb_dat_i[0], 1) || $past(wb_cyc_i && wb_we_i && wb_dat_i[0], 2))
        else $error("manual error without a write of one");
    irq_rise_a: assert property ($rose(irq) |->
        $past(pkt_start, 2) || $past(pkt_start, 3) || $past(wb_cyc_i && wb_we_i))
        else $error("irq rose without finish or enable write");
    irq_drop_a: assert property ($fell(irq) |->
        $past(wb_cyc_i, 1) || $past(wb_cyc_i, 2) || $past(wb_cyc_i, 3))
        else $error("irq fell without a bus access");
endmodule
bind tx_packet_error_insert_monitor tx_err_mon_props tx_err_mon_props_inst (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pkt_start(pkt_start), .byte_sent(byte_sent), .pkt_corrupt(pkt_corrupt),
    .manual_error(manual_error), .irq(irq));
`default_nettype wire

// ==== verification/tx_packet_error_insert_monitor_tb.sv ====
// Purpose: Self-checking bench for the transmit error insertion and monitor bank.
// Assumes: Packets come from the stream source model; bus waits are bounded.
// Notes:   Corrupt and manual pulses are counted here to judge insertion.
`timescale 1ns/1ps
`default_nettype none
`include "tx_err_mon_consts.vh"
module tx_packet_error_insert_monitor_tb;
    logic clk, rst_n, cyc, stb, we, go;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, v;
    logic [7:0] n_pkts, n_bytes, q;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, pkt_start, byte_sent, pkt_corrupt, manual_error, irq, busy;
    int errors, compares, cycles, corrupt_seen, manual_seen, c0, i;
    logic [7:0] rates [4] = '{8'h01, 8'h02, 8'h11, 8'h00};
    logic [7:0] hits [4] = '{8'h14, 8'h0A, 8'h02, 8'h00};
    logic [7:0] rst_idx [12] = '{8'hC8, 8'hCA, 8'hCC, 8'hCD, 8'hCE, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4,
        8'hD6, 8'hD7};
    tx_packet_error_insert_monitor tx_packet_error_insert_monitor_inst (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pkt_start(pkt_start), .byte_sent(byte_sent),
        .pkt_corrupt(pkt_corrupt), .manual_error(manual_error), .irq(irq));
    tdm_pkt_source tdm_pkt_source_inst (.clk(clk), .rst_n(rst_n), .go(go), .n_pkts(n_pkts),
        .n_bytes(n_bytes), .pkt_start(pkt_start), .byte_sent(byte_sent), .busy(busy));
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulse counters and a hang limit well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (pkt_corrupt === 1'b1) corrupt_seen++;
        if (manual_error === 1'b1) manual_seen++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled high
    // Waits for ack with no cycle limit of its own; the bench hang limit ends a stuck wait
    task automatic bus(input logic [7:0] idx, input logic is_wr, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= is_wr;
        adr <= {idx, 2'b00};
        dat_w <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check({24'h000000, q}, {24'h000000, exp});
    endtask
    // Multi-byte count, low byte at the lowest index
    task automatic rdcnt(input logic [7:0] idx, input int nb, output logic [31:0] val);
        val = 32'h0;
        for (int k = 0; k < nb; k++) begin
            bus(idx + k[7:0], 1'b0, 8'h00);
            val[8 * k +: 8] = q;
        end
    endtask
    task automatic send(input logic [7:0] np, input logic [7:0] nb);
        int n;
        n = 0;
        @(posedge clk);
        n_pkts <= np;
        n_bytes <= nb;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (busy === 1'b1 && n < 5000);
        repeat (4) @(posedge clk);
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {cyc, stb, we, go} = 4'h0;
        adr = 10'h000;
        sel = 4'hF;
        dat_w = 32'h0;
        n_pkts = 8'h00;
        n_bytes = 8'h01;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_idx[j]) rd(rst_idx[j], 8'h00);
        wr(8'h10, 8'h5A);
        rd(8'h10, 8'h00);
        send(8'h03, 8'h05);
        rdcnt(`IDX_PKT_CNT_B0, 3, v);
        check(v, 32'h0);
        wr(`IDX_MON_UPDATE, 8'h01);
        rd(`IDX_MON_UPD_STATUS, 8'h01);
        rdcnt(`IDX_PKT_CNT_B0, 3, v);
        check(v, 32'h3);
        rdcnt(`IDX_BYTE_CNT_B0, 4, v);
        check(v, 32'hF);
        wr(`IDX_MON_UPDATE, 8'h00);
        rd(`IDX_MON_UPD_STATUS, 8'h00);
        send(8'h02, 8'h04);
        wr(`IDX_MON_UPDATE, 8'h01);
        rdcnt(`IDX_BYTE_CNT_B0, 4, v);
        check(v, 32'h8);
        wr(`IDX_MON_UPDATE, 8'h00);
        // Masked run: count, rate, then initiate
        wr(`IDX_ERR_COUNT, 8'h01);
        wr(`IDX_ERR_RATE, 8'h01);
        c0 = corrupt_seen;
        wr(`IDX_PROC_CTRL, 8'h01);
        send(8'h03, 8'h01);
        check(corrupt_seen - c0, 32'h1);
        rd(`IDX_INS_STATUS, 8'h01);
        check({31'h0, irq}, 32'h0);
        rd(`IDX_INS_LATCHED, 8'h01);
        rd(`IDX_INS_LATCHED, 8'h00);
        wr(`IDX_PROC_CTRL, 8'h00);
        rd(`IDX_INS_STATUS, 8'h00);
        // Enabled run of two, then a restart clears the flag
        wr(`IDX_INS_IRQ_EN, 8'h01);
        wr(`IDX_ERR_COUNT, 8'h02);
        c0 = corrupt_seen;
        wr(`IDX_PROC_CTRL, 8'h01);
        send(8'h04, 8'h01);
        rd(`IDX_INS_STATUS, 8'h01);
        check(corrupt_seen - c0, 32'h2);
        check({31'h0, irq}, 32'h1);
        rd(`IDX_INS_LATCHED, 8'h01);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(`IDX_PROC_CTRL, 8'h01);
        rd(`IDX_INS_STATUS, 8'h00);
        // Endless insertion at several rates
        wr(`IDX_ERR_COUNT, `ERR_COUNT_ENDLESS);
        for (i = 0; i < 4; i++) begin
            wr(`IDX_ERR_RATE, rates[i]);
            c0 = corrupt_seen;
            wr(`IDX_PROC_CTRL, 8'h01);
            send(8'h14, 8'h01);
            check(corrupt_seen - c0, {24'h0, hits[i]});
            wr(`IDX_PROC_CTRL, 8'h00);
        end
        // Manual insert only with the mode bit set
        c0 = manual_seen;
        wr(`IDX_ERR_RATE, 8'h00);
        wr(`IDX_MANUAL_ERR, 8'h01);
        wr(`IDX_MANUAL_ERR, 8'h00);
        wr(`IDX_ERR_RATE, 8'h80);
        wr(`IDX_MANUAL_ERR, 8'h01);
        wr(`IDX_MANUAL_ERR, 8'h01);
        repeat (3) @(posedge clk);
        check(manual_seen - c0, 32'h1);
        // Cleanup: controls to zero, then initiate off
        wr(`IDX_ERR_COUNT, 8'h00);
        wr(`IDX_ERR_RATE, 8'h00);
        wr(`IDX_PROC_CTRL, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
